/* File: src/mcit_pkg.sv */
// Purpose: Shared constants for the match-clear interval timer
// Assumes: 16-bit register port, word index addressing
// Notes:   One register per index, narrow data in the low bits
package mcit_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int WIDE_W = 16;
  localparam int NARROW_W = 8;
  localparam int PRESC_W = 10;

  // Register indices
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_MASK = 4'h1;
  localparam logic [3:0] OFS_WIDE_OTHER = 4'h2;
  localparam logic [3:0] OFS_WIDE_CLEAR = 4'h3;
  localparam logic [3:0] OFS_NARROW_CMP = 4'h4;
  localparam logic [3:0] OFS_PRESC_SEL = 4'h5;
  localparam logic [3:0] OFS_CMP_CTRL2 = 4'h6;
  localparam logic [3:0] OFS_WIDE_CNT = 4'h7;
  localparam logic [3:0] OFS_NARROW_CNT = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'h9;

  // Control register fields
  localparam int CTRL_WIDE_RUN = 0;
  localparam int CTRL_WIDE_CLR = 1;
  localparam int CTRL_NARROW_RUN = 2;

  // Mask register fields
  localparam int MASK_WIDE = 0;
  localparam int MASK_NARROW = 1;

  // Compare control second: clear-on-match field
  localparam int CC2_NARROW_CLR = 4;

  // Prescaler select fields
  localparam int PSEL_NARROW_LSB = 4;
  localparam int PSEL_ZERO_BIT = 3;
  localparam logic [7:0] PSEL_WR_MASK = 8'hF7;

  // Reset values
  localparam logic [7:0] PSEL_RESET = 8'h00;
  localparam logic [7:0] CC2_RESET = 8'h00;
  localparam logic [1:0] MASK_RESET = 2'h3;

  // Narrow clock select codes
  localparam logic [3:0] SEL_DIV16 = 4'h1;
  localparam logic [3:0] SEL_DIV32 = 4'h3;
  localparam logic [3:0] SEL_DIV64 = 4'h4;
  localparam logic [3:0] SEL_DIV128 = 4'h5;
  localparam logic [3:0] SEL_DIV256 = 4'h6;
  localparam logic [3:0] SEL_DIV512 = 4'h7;
  localparam logic [3:0] SEL_EXT = 4'hF;

  // Dividers as log2 of clock cycles per tick; WIDE_FCLK_LOG2 counts fclk cycles, the others ref cycles
  localparam int FCLK_LOG2 = 1;
  localparam int WIDE_FCLK_LOG2 = 3;
  localparam int WIDE_LOG2 = FCLK_LOG2 + WIDE_FCLK_LOG2;

endpackage : mcit_pkg

/* File: src/mcit_prescaler.sv */
// Purpose: Count-clock enables for both counters
// Assumes: ref_clk_i is the oscillator, external input is synchronous
// Notes:   Ticks are one-cycle enables, never derived clocks
`timescale 1ns/1ps
module mcit_prescaler #(
  parameter int PW = mcit_pkg::PRESC_W
) (
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic [3:0] narrow_sel_i,
  input  wire logic       ext_count_i,
  output logic            wide_tick_o,
  output logic            narrow_tick_o
);

  logic [PW-1:0] div_reg;
  logic          ext_prev_reg;
  logic [PW-1:0] narrow_mask;
  logic [PW-1:0] wide_mask;
  logic          narrow_int;
  logic          ext_rise;

  // Log2 of the fclk divisor for a select code, zero when unused
  function automatic logic [3:0] sel_log2(input logic [3:0] sel);
    unique case (sel)
      mcit_pkg::SEL_DIV16:  sel_log2 = 4'h4;
      mcit_pkg::SEL_DIV32:  sel_log2 = 4'h5;
      mcit_pkg::SEL_DIV64:  sel_log2 = 4'h6;
      mcit_pkg::SEL_DIV128: sel_log2 = 4'h7;
      mcit_pkg::SEL_DIV256: sel_log2 = 4'h8;
      mcit_pkg::SEL_DIV512: sel_log2 = 4'h9;
      default:              sel_log2 = 4'h0;
    endcase
  endfunction : sel_log2

  // Free divider; fclk is every second ref edge [R18]
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_count_i;
    end
  end

  assign wide_mask = PW'((1 << mcit_pkg::WIDE_LOG2) - 1);
  assign narrow_mask = PW'((1 << (sel_log2(narrow_sel_i) + mcit_pkg::FCLK_LOG2)) - 1);
  // Unused codes give no tick at all, so the counter just holds
  assign narrow_int = (sel_log2(narrow_sel_i) != 4'h0) &&
                      ((div_reg & narrow_mask) == narrow_mask);
  assign ext_rise = ext_count_i && !ext_prev_reg;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wide_tick_o   <= 1'b0;
      narrow_tick_o <= 1'b0;
    end else begin
      wide_tick_o   <= (div_reg & wide_mask) == wide_mask;           // [R2]
      narrow_tick_o <= (narrow_sel_i == mcit_pkg::SEL_EXT) ? ext_rise // [R17]
                                                          : narrow_int; // [R13]
    end
  end

endmodule : mcit_prescaler

/* File: src/mcit_top.sv */
// Purpose: Two-channel match-clear interval timer with register port
// Assumes: Oscillator on ref_clk_i, synchronous inputs, 16-bit port
// Notes:   Match requests are one-cycle pulses from flops
// Operation
// (R1) Each channel repeats its request at fixed period
// (R2) Wide counter ticks at internal clock over eight
// (R3) Wide interval is n plus one ticks
// (R4) Wide request on counter equal clear compare
// (R5) Wide clear-on-match option clears counter
// (R6) Only the clear compare clears; other never
// (R7) Wide request passes only when mask clear
// (R8) Wide counter runs only after enable set
// (R9) Narrow interval n plus one prescaled ticks
// (R10) Narrow request on counter equal compare
// (R11) Narrow clear-on-match option clears counter
// (R12) Narrow compare holds programmed interval value
// (R13) Narrow count clock chosen through prescaler
// (R14) Narrow request passes only when mask clear
// (R15) Narrow counter counts only while enabled
// (R16) Prescaler select eight bits, bit three zero
// (R17) Four-bit select decodes dividers and external
// (R18) Internal clock is oscillator divided by two
// (R19) Control-second clear bit enables narrow clear
// (R20) Clearing match reloads zero on next tick
// (R21) Reset: stopped, zero, no clear, masked
`timescale 1ns/1ps
module mcit_top #(
  parameter int WW = mcit_pkg::WIDE_W,
  parameter int NW = mcit_pkg::NARROW_W
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        resetn_i,
  input  wire logic [mcit_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [mcit_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  input  wire logic                        external_count_input_i,
  output logic      [mcit_pkg::DATA_W-1:0] rdata_o,
  output logic                             wide_match_irq_o,
  output logic                             wide_other_match_o,
  output logic                             narrow_match_irq_o
);

  logic [WW-1:0] wide_counter_reg;
  logic [WW-1:0] wide_counter_next;
  logic [WW-1:0] wide_clear_compare_reg;
  logic [WW-1:0] wide_other_compare_reg;
  logic [NW-1:0] narrow_counter_reg;
  logic [NW-1:0] narrow_counter_next;
  logic [NW-1:0] narrow_compare_reg;
  logic [7:0]    prescaler_select_reg;
  logic [7:0]    compare_ctrl_second_reg;
  logic          wide_run_reg;
  logic          wide_clr_en_reg;
  logic          narrow_run_reg;
  logic          wide_mask_reg;
  logic          narrow_mask_reg;
  logic          wide_match_seen_reg;
  logic          narrow_match_seen_reg;
  logic [mcit_pkg::DATA_W-1:0] rdata_next;
  logic          wide_tick;
  logic          narrow_tick;
  logic          wide_step;
  logic          narrow_step;
  logic          wide_eq;
  logic          wide_other_eq;
  logic          narrow_eq;
  logic          narrow_clr_en;

  function automatic logic hit(input logic [mcit_pkg::ADDR_W-1:0] ofs);
    hit = wr_i && (addr_i == ofs);
  endfunction : hit

  mcit_prescaler #(
    .PW (mcit_pkg::PRESC_W)
  ) u_presc (
    .ref_clk_i     (ref_clk_i),
    .resetn_i      (resetn_i),
    .narrow_sel_i  (prescaler_select_reg[mcit_pkg::PSEL_NARROW_LSB +: 4]),
    .ext_count_i   (external_count_input_i),
    .wide_tick_o   (wide_tick),
    .narrow_tick_o (narrow_tick)
  );

  // Counter decisions
  assign wide_step = wide_tick && wide_run_reg;                          // [R8]
  assign narrow_step = narrow_tick && narrow_run_reg;                    // [R15]
  assign wide_eq = wide_counter_reg == wide_clear_compare_reg;           // [R4]
  assign wide_other_eq = wide_counter_reg == wide_other_compare_reg;
  assign narrow_eq = narrow_counter_reg == narrow_compare_reg;           // [R10] [R12]
  assign narrow_clr_en = compare_ctrl_second_reg[mcit_pkg::CC2_NARROW_CLR]; // [R19]

  // Only the clear compare may reload zero; n+1 ticks per interval
  assign wide_counter_next = (wide_clr_en_reg && wide_eq) ? '0           // [R5] [R6] [R20]
                                                          : wide_counter_reg + 1'b1; // [R3]
  assign narrow_counter_next = (narrow_clr_en && narrow_eq) ? '0         // [R11] [R20]
                                                            : narrow_counter_reg + 1'b1; // [R9]

  // Control and mask registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wide_run_reg    <= 1'b0;                                           // [R21]
      wide_clr_en_reg <= 1'b0;
      narrow_run_reg  <= 1'b0;
    end else if (hit(mcit_pkg::OFS_CTRL)) begin
      wide_run_reg    <= wdata_i[mcit_pkg::CTRL_WIDE_RUN];
      wide_clr_en_reg <= wdata_i[mcit_pkg::CTRL_WIDE_CLR];
      narrow_run_reg  <= wdata_i[mcit_pkg::CTRL_NARROW_RUN];
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wide_mask_reg   <= mcit_pkg::MASK_RESET[mcit_pkg::MASK_WIDE];     // [R21]
      narrow_mask_reg <= mcit_pkg::MASK_RESET[mcit_pkg::MASK_NARROW];
    end else if (hit(mcit_pkg::OFS_MASK)) begin
      wide_mask_reg   <= wdata_i[mcit_pkg::MASK_WIDE];
      narrow_mask_reg <= wdata_i[mcit_pkg::MASK_NARROW];
    end
  end

  // Compare registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wide_clear_compare_reg <= '0;
      wide_other_compare_reg <= '0;
    end else begin
      if (hit(mcit_pkg::OFS_WIDE_CLEAR)) begin
        wide_clear_compare_reg <= wdata_i[WW-1:0];
      end
      if (hit(mcit_pkg::OFS_WIDE_OTHER)) begin
        wide_other_compare_reg <= wdata_i[WW-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      narrow_compare_reg <= '0;
    end else if (hit(mcit_pkg::OFS_NARROW_CMP)) begin
      narrow_compare_reg <= wdata_i[NW-1:0];                             // [R12]
    end
  end

  // Selection registers; select bit 3 is forced to zero
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prescaler_select_reg    <= mcit_pkg::PSEL_RESET;
      compare_ctrl_second_reg <= mcit_pkg::CC2_RESET;                    // [R21]
    end else begin
      if (hit(mcit_pkg::OFS_PRESC_SEL)) begin
        prescaler_select_reg <= wdata_i[7:0] & mcit_pkg::PSEL_WR_MASK;   // [R16]
      end
      if (hit(mcit_pkg::OFS_CMP_CTRL2)) begin
        compare_ctrl_second_reg <= wdata_i[7:0];
      end
    end
  end

  // Counters: software may not write them, reset or a clearing match clears them
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wide_counter_reg <= '0;                                            // [R21]
    end else if (wide_step) begin
      wide_counter_reg <= wide_counter_next;                             // [R2]
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      narrow_counter_reg <= '0;                                          // [R21]
    end else if (narrow_step) begin
      narrow_counter_reg <= narrow_counter_next;                         // [R13]
    end
  end

  // Requests, one pulse per matching tick
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wide_match_irq_o   <= 1'b0;
      wide_other_match_o <= 1'b0;
      narrow_match_irq_o <= 1'b0;
    end else begin
      wide_match_irq_o   <= wide_step && wide_eq && !wide_mask_reg;      // [R1] [R4] [R7]
      wide_other_match_o <= wide_step && wide_other_eq;                  // [R6]
      narrow_match_irq_o <= narrow_step && narrow_eq && !narrow_mask_reg; // [R1] [R14]
    end
  end

  // Raw match history readable even while masked; read clears, set wins
  // Lets software poll a channel whose request stays masked
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wide_match_seen_reg   <= 1'b0;
      narrow_match_seen_reg <= 1'b0;
    end else begin
      if (wide_step && wide_eq) begin
        wide_match_seen_reg <= 1'b1;
      end else if (rd_i && addr_i == mcit_pkg::OFS_STATUS) begin
        wide_match_seen_reg <= 1'b0;
      end
      if (narrow_step && narrow_eq) begin
        narrow_match_seen_reg <= 1'b1;
      end else if (rd_i && addr_i == mcit_pkg::OFS_STATUS) begin
        narrow_match_seen_reg <= 1'b0;
      end
    end
  end

  // Read mux
  always_comb begin
    rdata_next = '0;
    unique case (addr_i)
      mcit_pkg::OFS_CTRL: begin
        rdata_next[mcit_pkg::CTRL_WIDE_RUN]   = wide_run_reg;
        rdata_next[mcit_pkg::CTRL_WIDE_CLR]   = wide_clr_en_reg;
        rdata_next[mcit_pkg::CTRL_NARROW_RUN] = narrow_run_reg;
      end
      mcit_pkg::OFS_MASK: begin
        rdata_next[mcit_pkg::MASK_WIDE]   = wide_mask_reg;
        rdata_next[mcit_pkg::MASK_NARROW] = narrow_mask_reg;
      end
      mcit_pkg::OFS_WIDE_OTHER: rdata_next[WW-1:0] = wide_other_compare_reg;
      mcit_pkg::OFS_WIDE_CLEAR: rdata_next[WW-1:0] = wide_clear_compare_reg;
      mcit_pkg::OFS_NARROW_CMP: rdata_next[NW-1:0] = narrow_compare_reg;
      mcit_pkg::OFS_PRESC_SEL:  rdata_next[7:0] = prescaler_select_reg;
      mcit_pkg::OFS_CMP_CTRL2:  rdata_next[7:0] = compare_ctrl_second_reg;
      mcit_pkg::OFS_WIDE_CNT:   rdata_next[WW-1:0] = wide_counter_reg;
      mcit_pkg::OFS_NARROW_CNT: rdata_next[NW-1:0] = narrow_counter_reg;
      mcit_pkg::OFS_STATUS: begin
        rdata_next[0] = wide_match_seen_reg;
        rdata_next[1] = narrow_match_seen_reg;
      end
      default:                  rdata_next = '0;
    endcase
  end

  // Read data only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? rdata_next : '0;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_wide_tick_rate: assert property (wide_tick |=> !wide_tick [*8]) // [R2]
    else $error("wide tick too frequent");

  a_wide_irq_cause: assert property (wide_match_irq_o |->           // [R4]
    $past(wide_step) && $past(wide_eq) && !$past(wide_mask_reg))
    else $error("wide request without unmasked match");

  a_wide_mask_gate: assert property (wide_mask_reg && $stable(wide_mask_reg) // [R7]
    |-> !wide_match_irq_o)
    else $error("masked wide request passed");

  a_wide_clear_zero: assert property (wide_step && wide_clr_en_reg && wide_eq // [R5]
    |=> wide_counter_reg == '0)
    else $error("wide counter not cleared on match");

  a_wide_other_keep: assert property (wide_step && !(wide_clr_en_reg && wide_eq) // [R6]
    |=> wide_counter_reg == $past(wide_counter_reg) + 1'b1)
    else $error("wide counter did not advance");

  a_wide_stop_hold: assert property (!wide_run_reg ##1 !wide_run_reg // [R8]
    |-> $stable(wide_counter_reg))
    else $error("wide counter moved while stopped");

  a_narrow_irq_cause: assert property (narrow_match_irq_o |->       // [R10]
    $past(narrow_step) && $past(narrow_eq) && !$past(narrow_mask_reg))
    else $error("narrow request without unmasked match");

  a_narrow_clear_zero: assert property (narrow_step && narrow_clr_en && narrow_eq // [R11]
    |=> narrow_counter_reg == '0)
    else $error("narrow counter not cleared on match");

  a_narrow_stop_hold: assert property (!narrow_run_reg ##1 !narrow_run_reg // [R15]
    |-> $stable(narrow_counter_reg))
    else $error("narrow counter moved while stopped");

  a_presc_zero_bit: assert property (!prescaler_select_reg[mcit_pkg::PSEL_ZERO_BIT]) // [R16]
    else $error("prescaler select bit three set");

  // Pulse shape, gating and match history
  a_wide_irq_pulse: assert property ( // [R1]
    wide_match_irq_o |=> !wide_match_irq_o)
    else $error("wide request longer than one cycle");

  a_narrow_irq_pulse: assert property ( // [R1]
    narrow_match_irq_o |=> !narrow_match_irq_o)
    else $error("narrow request longer than one cycle");

  a_wide_tick_period: assert property ( // [R2]
    wide_tick |-> ##16 wide_tick)
    else $error("wide tick period wrong");

  a_wide_other_cause: assert property ( // [R6]
    wide_other_match_o |-> $past(wide_step) && $past(wide_other_eq))
    else $error("other match pulse without match");

  a_wide_run_gate: assert property ( // [R8]
    wide_match_irq_o |-> $past(wide_run_reg))
    else $error("wide request while stopped");

  a_narrow_keep_count: assert property ( // [R9]
    narrow_step && !(narrow_clr_en && narrow_eq)
    |=> narrow_counter_reg == $past(narrow_counter_reg) + 1'b1)
    else $error("narrow counter did not advance");

  a_narrow_run_gate: assert property ( // [R15]
    narrow_match_irq_o |-> $past(narrow_run_reg))
    else $error("narrow request while stopped");

  a_narrow_mask_gate: assert property ( // [R14]
    narrow_mask_reg && $stable(narrow_mask_reg) |-> !narrow_match_irq_o)
    else $error("masked narrow request passed");

  a_wide_seen_set: assert property ( // [R4]
    wide_step && wide_eq |=> wide_match_seen_reg)
    else $error("wide match not recorded");

  a_narrow_seen_set: assert property ( // [R10]
    narrow_step && narrow_eq |=> narrow_match_seen_reg)
    else $error("narrow match not recorded");

  a_status_clear: assert property ( // [R4]
    rd_i && addr_i == mcit_pkg::OFS_STATUS && !(wide_step && wide_eq) |=> !wide_match_seen_reg)
    else $error("wide match history not cleared by read");

  a_ext_tick_cause: assert property (narrow_tick && $stable(prescaler_select_reg) && // [R17]
    prescaler_select_reg[mcit_pkg::PSEL_NARROW_LSB +: 4] == mcit_pkg::SEL_EXT
    |-> $past(external_count_input_i))
    else $error("external tick without input edge");

  c_wide_irq: cover property (wide_match_irq_o ##[1:300] wide_match_irq_o);
  c_narrow_irq: cover property (narrow_match_irq_o);
  c_narrow_ext: cover property (narrow_tick &&
    prescaler_select_reg[mcit_pkg::PSEL_NARROW_LSB +: 4] == mcit_pkg::SEL_EXT);
  c_other_match: cover property (wide_other_match_o);
  c_narrow_wrap: cover property (narrow_step && narrow_eq && !narrow_clr_en);

endmodule : mcit_top

/* File: dv/mcit_irq_sink.sv */
// Purpose: Interrupt-side model that counts requests and times them
// Assumes: Requests are one-cycle pulses sampled on ref_clk_i
// Notes:   Period is ref cycles between the two latest pulses
`timescale 1ns/1ps
module mcit_irq_sink (
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  input  wire logic irq_i,
  output int        count_o,
  output int        period_o
);
  int cyc;
  int last;

  // Counts only clean highs, so an unknown request is never taken
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cyc = 0;
      last = 0;
      count_o = 0;
      period_o = 0;
    end else begin
      cyc = cyc + 1;
      if (irq_i === 1'b1) begin
        if (count_o > 0) begin
          period_o = cyc - last;
        end
        last = cyc;
        count_o = count_o + 1;
      end
    end
  end
endmodule : mcit_irq_sink

/* File: dv/mcit_top_tb.sv */
// Purpose: Self-checking bench for the match-clear interval timer
// Assumes: Register port with one-cycle strobes, read data one cycle later
// Notes:   Expected periods in ref cycles: wide 16(n+1), narrow 2X(n+1)
`timescale 1ns/1ps
module mcit_top_tb;
  logic                          ref_clk_i = 1'b0;
  logic                          resetn_i = 1'b0;
  logic [mcit_pkg::ADDR_W-1:0]   addr_i = 4'h0;
  logic [mcit_pkg::DATA_W-1:0]   wdata_i = 16'h0000;
  logic                          wr_i = 1'b0;
  logic                          rd_i = 1'b0;
  logic                          ext_i = 1'b0;
  logic [mcit_pkg::DATA_W-1:0]   rdata_o;
  logic                          wide_irq;
  logic                          other_irq;
  logic                          narrow_irq;
  int                            err_total = 0;
  int                            total_checks = 0;
  int                            cycles = 0;
  int                            wc, wp, oc, op, nc, np, k;
  logic [3:0]  ra [7] = '{4'h0, 4'h1, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA};
  logic [15:0] re [7] = '{16'h0000, 16'h0003, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] wn [3] = '{16'h0000, 16'h0003, 16'h0009};
  logic [3:0]  nsel [6] = '{mcit_pkg::SEL_DIV16, mcit_pkg::SEL_DIV32, mcit_pkg::SEL_DIV64,
                            mcit_pkg::SEL_DIV128, mcit_pkg::SEL_DIV256, mcit_pkg::SEL_DIV512};
  int          xs [6] = '{16, 32, 64, 128, 256, 512};

  always #5 ref_clk_i = ~ref_clk_i;

  mcit_top i_dut (
    .ref_clk_i              (ref_clk_i),
    .resetn_i               (resetn_i),
    .addr_i                 (addr_i),
    .wdata_i                (wdata_i),
    .wr_i                   (wr_i),
    .rd_i                   (rd_i),
    .external_count_input_i (ext_i),
    .rdata_o                (rdata_o),
    .wide_match_irq_o       (wide_irq),
    .wide_other_match_o     (other_irq),
    .narrow_match_irq_o     (narrow_irq)
  );
  mcit_irq_sink i_wide (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .irq_i(wide_irq),
                        .count_o(wc), .period_o(wp));
  mcit_irq_sink i_other (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .irq_i(other_irq),
                         .count_o(oc), .period_o(op));
  mcit_irq_sink i_narrow (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .irq_i(narrow_irq),
                          .count_o(nc), .period_o(np));

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic fail(input string m);
    err_total++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : fail

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) fail(m);
  endtask : chk16

  task automatic chk_int(input int got, input int exp, input string m);
    total_checks++;
    if (got != exp) fail(m);
  endtask : chk_int

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd

  task automatic do_reset();
    resetn_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
  endtask : do_reset

  function automatic int cnt(input int sel);
    return sel == 0 ? wc : (sel == 1 ? oc : nc);
  endfunction : cnt

  // Bounded wait for n further pulses on one request line
  task automatic wait_pulses(input int sel, input int n, input int lim);
    int base;
    base = cnt(sel);
    for (int i = 0; i < lim && cnt(sel) < base + n; i++) @(posedge ref_clk_i);
  endtask : wait_pulses

  // Narrow channel setup; counter restarts from zero after reset
  task automatic narrow_cfg(input logic [3:0] code, input logic [15:0] n, input logic clr);
    do_reset();
    wr(mcit_pkg::OFS_NARROW_CMP, n);
    wr(mcit_pkg::OFS_PRESC_SEL, {8'h00, code, 4'h0});
    wr(mcit_pkg::OFS_CMP_CTRL2, {11'h000, clr, 4'h0});
    wr(mcit_pkg::OFS_MASK, 16'h0001);
    wr(mcit_pkg::OFS_CTRL, 16'h0004);
  endtask : narrow_cfg

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      fail("timeout");
      end_sim();
    end
  end

  initial begin
    logic [15:0] v;
    logic [15:0] v2;
    do_reset();
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], v);
      chk16(v, re[i], "reset or unmapped value");
    end
    wr(mcit_pkg::OFS_PRESC_SEL, 16'hFFFF);
    rd(mcit_pkg::OFS_PRESC_SEL, v);
    chk16(v, 16'h00F7, "prescaler select bit 3");
    wr(mcit_pkg::OFS_WIDE_CLEAR, 16'h0003);
    wr(mcit_pkg::OFS_MASK, 16'h0002);
    repeat (64) @(posedge ref_clk_i);
    rd(mcit_pkg::OFS_WIDE_CNT, v);
    chk16(v, 16'h0000, "wide counter not stopped");
    chk_int(wc, 0, "wide request while stopped");
    foreach (wn[i]) begin
      do_reset();
      wr(mcit_pkg::OFS_WIDE_OTHER, wn[i] >> 1);
      wr(mcit_pkg::OFS_WIDE_CLEAR, wn[i]);
      wr(mcit_pkg::OFS_MASK, 16'h0002);
      wr(mcit_pkg::OFS_CTRL, 16'h0003);
      wait_pulses(0, 3, 64 * (int'(wn[i]) + 1) + 100);
      chk_int(wp, 16 * (int'(wn[i]) + 1), "wide period");
      chk_int(op, 16 * (int'(wn[i]) + 1), "other compare period");
    end
    wr(mcit_pkg::OFS_MASK, 16'h0003);
    repeat (2) @(posedge ref_clk_i);
    k = wc;
    repeat (400) @(posedge ref_clk_i);
    chk_int(wc, k, "wide request while masked");
    do_reset();
    wr(mcit_pkg::OFS_WIDE_CLEAR, 16'h0002);
    wr(mcit_pkg::OFS_MASK, 16'h0002);
    wr(mcit_pkg::OFS_CTRL, 16'h0001);
    repeat (160) @(posedge ref_clk_i);
    rd(mcit_pkg::OFS_WIDE_CNT, v);
    chk16({15'h0000, v > 16'h0002}, 16'h0001, "wide cleared without option");
    chk_int(wc, 1, "wide match count without clear");
    rd(mcit_pkg::OFS_STATUS, v);
    chk16(v, 16'h0001, "match history after wide match");
    rd(mcit_pkg::OFS_STATUS, v);
    chk16(v, 16'h0000, "match history not cleared by read");
    foreach (nsel[i]) begin
      narrow_cfg(nsel[i], 16'h0001, 1'b1);
      wait_pulses(2, 3, 16 * xs[i] + 100);
      chk_int(np, 4 * xs[i], "narrow period");
    end
    rd(mcit_pkg::OFS_NARROW_CMP, v);
    chk16(v, 16'h0001, "narrow compare readback");
    wr(mcit_pkg::OFS_MASK, 16'h0003);
    repeat (2) @(posedge ref_clk_i);
    k = nc;
    repeat (4200) @(posedge ref_clk_i);
    chk_int(nc, k, "narrow request while masked");
    wr(mcit_pkg::OFS_CTRL, 16'h0000);
    rd(mcit_pkg::OFS_NARROW_CNT, v);
    // Reads exactly one narrow tick apart, so a running count must differ
    repeat (1022) @(posedge ref_clk_i);
    rd(mcit_pkg::OFS_NARROW_CNT, v2);
    chk16(v2, v, "narrow counted while disabled");
    narrow_cfg(mcit_pkg::SEL_DIV16, 16'h0001, 1'b0);
    wait_pulses(2, 2, 20000);
    chk_int(np, 256 * 32, "narrow wrap period without clear");
    narrow_cfg(mcit_pkg::SEL_EXT, 16'h0002, 1'b1);
    repeat (6) begin
      @(posedge ref_clk_i);
      ext_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      ext_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
    end
    repeat (4) @(posedge ref_clk_i);
    chk_int(nc, 2, "external count matches");
    wr(mcit_pkg::OFS_PRESC_SEL, 16'h0020);
    repeat (1200) @(posedge ref_clk_i);
    chk_int(nc, 2, "unused select code ticked");
    end_sim();
  end
endmodule : mcit_top_tb
